/* pkg/msc_pkg.sv */
// package: register map, field layout and status carriers of the frame statistics counters
package msc_pkg;

	// counter set
	localparam int NCNT      = 10;
	localparam int CNT_W     = 24;
	localparam int CI_SCOL   = 0;
	localparam int CI_MCOL   = 1;
	localparam int CI_GOODRX = 2;
	localparam int CI_CRC    = 3;
	localparam int CI_ALIGN  = 4;
	localparam int CI_DEFER  = 5;
	localparam int CI_LATE   = 6;
	localparam int CI_EXCESS_COLLISION_TALLY  = 7;
	localparam int CI_STARVE = 8;
	localparam int CI_CLOSS  = 9;

	// register offsets (byte addresses)
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] CNT_OFF [NCNT] = '{
		8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28};

	// saturation values, i.e. the counter widths 16,16,24,8,8,16,8,8,8,8
	localparam logic [CNT_W-1:0] CNT_MAX [NCNT] = '{
		24'h00ffff, 24'h00ffff, 24'hffffff, 24'h0000ff, 24'h0000ff,
		24'h00ffff, 24'h0000ff, 24'h0000ff, 24'h0000ff, 24'h0000ff};
	localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;

	// control register fields
	localparam int          CTRL_RXEN_BIT = 2;
	localparam int          CTRL_STWR_BIT = 7;
	localparam int          CTRL_BIG_BIT  = 8;
	localparam int          CTRL_HDX_BIT  = 9;
	localparam logic [31:0] CTRL_MASK     = 32'h0000_0384;
	localparam logic [31:0] CTRL_RST      = 32'h0000_0000;

	// frame limits
	localparam logic [13:0] LEN_MIN     = 14'd64;
	localparam logic [13:0] LEN_MAX     = 14'd1518;
	localparam logic [13:0] LEN_MAX_BIG = 14'd1536;
	localparam logic [4:0]  COLL_MULTI_HI = 5'd15;
	localparam logic [4:0]  COLL_EXCESS   = 5'd16;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} msc_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} msc_wb_rsp_t;

	// one-cycle final status of a transmitted frame
	typedef struct packed {
		logic       valid;
		logic [4:0] ncoll;
		logic       late_coll;
		logic       underrun;
		logic       deferred;
		logic       carrier_err;
	} msc_tx_stat_t;

	// one-cycle final status of a received frame
	typedef struct packed {
		logic        valid;
		logic [13:0] len;
		logic        odd_bits;
		logic        crc_bad;
		logic        sym_err;
		logic        addr_match;
		logic        stored;
	} msc_rx_stat_t;

endpackage

/* rtl/msc_stats.sv */
// module: frame statistics counters with a classic wishbone register slave
//
// Notes on behaviour
// - count frames sent without underrun after exactly one collision, 16 bits.
// - count frames sent after two to fifteen collisions, no underrun, 16 bits.
// - count good received frames that matched address and were stored, 24 bits.
// - good frame is 64 to 1518 bytes, 1536 with large frames, no errors.
// - count valid-length whole-byte frames with bad CRC, 8 bits.
// - a symbol error on a valid whole-byte frame also counts as CRC error.
// - count valid-length frames with stray bits and bad truncated CRC, 8 bits.
// - a symbol error on a valid frame with stray bits counts as alignment error.
// - count frames deferred by carrier sense on first attempt, 16 bits.
// - deferral count skips frames with any collision or underrun.
// - count frames with a collision after the 512-bit slot time, 8 bits.
// - a late collision counts as late and as an ordinary collision.
// - count frames dropped after 16 collisions, 8 bits.
// - count frames lost to transmit DMA starvation, 8 bits.
// - a starved frame advances no counter but the starvation count.
// - count clean frames where carrier sense was absent or dropped, 8 bits.
// - carrier loss count advances only in half duplex.
// - a carrier sense error leaves all other counters unaffected.
// - counters clear on read and stick at all ones.
// - software writes to counters only while control bit 7 is set.
// - receive counters advance only while receive is enabled.
`timescale 1ns/100ps

module msc_stats (
	// clock and reset
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_rst,
	// register bus
	input  wire msc_pkg::msc_wb_req_t  i_wb,
	output msc_pkg::msc_wb_rsp_t       o_wb,
	// frame status from the mac engines
	input  wire msc_pkg::msc_tx_stat_t i_tx,
	input  wire msc_pkg::msc_rx_stat_t i_rx
);
	import msc_pkg::*;

	typedef struct packed {
		logic                       ack;
		logic [31:0]                rdat;
		logic [31:0]                ctrl;
		logic [NCNT-1:0][CNT_W-1:0] cnt;
	} msc_state_t;

	msc_state_t        state_q;
	msc_state_t        state_d;
	logic              bus_take;
	logic              rx_len_ok;
	logic [13:0]       rx_len_top;
	logic              tx_ok;
	logic              rx_on;
	logic [NCNT-1:0]   inc;
	logic [NCNT-1:0]   rd_hit;
	logic [NCNT-1:0]   wr_hit;
	logic [31:0]       wmask;

	// requests are taken only while ack is low, so each access acts exactly once
	assign bus_take = i_wb.cyc & i_wb.stb & ~state_q.ack;
	assign wmask    = {{8{i_wb.sel[3]}}, {8{i_wb.sel[2]}}, {8{i_wb.sel[1]}}, {8{i_wb.sel[0]}}};

	// receive classification
	assign rx_len_top = state_q.ctrl[CTRL_BIG_BIT] ? LEN_MAX_BIG : LEN_MAX;
	assign rx_len_ok  = (i_rx.len >= LEN_MIN) && (i_rx.len <= rx_len_top);
	assign rx_on      = i_rx.valid & state_q.ctrl[CTRL_RXEN_BIT];
	// starved frames are excluded everywhere except the starvation count
	assign tx_ok      = i_tx.valid & ~i_tx.underrun;

	// increment requests, one per final status pulse
	always_comb begin
		inc = '0;
		// the collision count includes any late collision
		inc[CI_SCOL]   = tx_ok && (i_tx.ncoll == 5'd1);
		inc[CI_MCOL]   = tx_ok && (i_tx.ncoll >= 5'd2) && (i_tx.ncoll <= COLL_MULTI_HI);
		inc[CI_GOODRX] = rx_on && rx_len_ok && ~i_rx.crc_bad && ~i_rx.sym_err &&
			i_rx.addr_match && i_rx.stored;
		inc[CI_CRC]    = rx_on && rx_len_ok && ~i_rx.odd_bits && (i_rx.crc_bad | i_rx.sym_err);
		inc[CI_ALIGN]  = rx_on && rx_len_ok && i_rx.odd_bits && (i_rx.crc_bad | i_rx.sym_err);
		inc[CI_DEFER]  = tx_ok && i_tx.deferred && (i_tx.ncoll == 5'd0);
		inc[CI_LATE]   = tx_ok && i_tx.late_coll;
		inc[CI_EXCESS_COLLISION_TALLY]  = tx_ok && (i_tx.ncoll == COLL_EXCESS);
		inc[CI_STARVE] = i_tx.valid && i_tx.underrun;
		// other counters ignore the carrier flag entirely
		inc[CI_CLOSS]  = tx_ok && i_tx.carrier_err && (i_tx.ncoll == 5'd0) &&
			state_q.ctrl[CTRL_HDX_BIT];
	end

	// address decode
	always_comb begin
		rd_hit = '0;
		wr_hit = '0;
		for (int i = 0; i < NCNT; i++) begin
			rd_hit[i] = bus_take && ~i_wb.we && (i_wb.adr[7:2] == CNT_OFF[i][7:2]);
			wr_hit[i] = bus_take && i_wb.we && state_q.ctrl[CTRL_STWR_BIT] &&
				(i_wb.adr[7:2] == CNT_OFF[i][7:2]);
		end
	end

	// next state
	always_comb begin
		state_d     = state_q;
		state_d.ack = bus_take;
		if (bus_take && i_wb.we && (i_wb.adr[7:2] == OFF_CTRL[7:2])) begin
			state_d.ctrl = ((state_q.ctrl & ~wmask) | (i_wb.dat & wmask)) & CTRL_MASK;
		end
		if (bus_take && ~i_wb.we) begin
			// unmapped addresses read as zero and writes to them are dropped
			state_d.rdat = '0;
			if (i_wb.adr[7:2] == OFF_CTRL[7:2]) begin
				state_d.rdat = state_q.ctrl;
			end
			for (int i = 0; i < NCNT; i++) begin
				if (rd_hit[i]) begin
					state_d.rdat = {8'h00, state_q.cnt[i]};
				end
			end
		end
		for (int i = 0; i < NCNT; i++) begin
			if (wr_hit[i]) begin
				state_d.cnt[i] = ((state_q.cnt[i] & ~wmask[CNT_W-1:0]) |
					(i_wb.dat[CNT_W-1:0] & wmask[CNT_W-1:0])) & CNT_MAX[i];
			end else if (rd_hit[i]) begin
				// an event in the clearing cycle is kept, so none is lost
				state_d.cnt[i] = inc[i] ? 24'h000001 : CNT_RST;
			end else if (inc[i] && (state_q.cnt[i] != CNT_MAX[i])) begin
				state_d.cnt[i] = state_q.cnt[i] + 24'h000001;
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			state_q.ack  <= 1'b0;
			state_q.rdat <= 32'h0000_0000;
			state_q.ctrl <= CTRL_RST;
			for (int i = 0; i < NCNT; i++) begin
				state_q.cnt[i] <= CNT_RST;
			end
		end else begin
			state_q <= state_d;
		end
	end

	assign o_wb = '{ack: state_q.ack, dat: state_q.rdat};

	// checks
	logic quiet;
	assign quiet = ~(i_wb.cyc & i_wb.stb);

	a_single_coll_count: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && i_tx.valid && !i_tx.underrun && i_tx.ncoll == 5'd1 &&
			state_q.cnt[CI_SCOL] != CNT_MAX[CI_SCOL])
		|=> state_q.cnt[CI_SCOL] == $past(state_q.cnt[CI_SCOL]) + 24'h000001)
		else $error("single collision frame not counted");

	a_starve_alone: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && i_tx.valid && i_tx.underrun && !i_rx.valid)
		|=> $stable(state_q.cnt[CI_SCOL]) && $stable(state_q.cnt[CI_MCOL]) &&
			$stable(state_q.cnt[CI_DEFER]) && $stable(state_q.cnt[CI_LATE]) &&
			$stable(state_q.cnt[CI_EXCESS_COLLISION_TALLY]) && $stable(state_q.cnt[CI_CLOSS]))
		else $error("starved frame touched another counter");

	a_rx_gate_off: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && !state_q.ctrl[CTRL_RXEN_BIT])
		|=> $stable(state_q.cnt[CI_GOODRX]) && $stable(state_q.cnt[CI_CRC]) &&
			$stable(state_q.cnt[CI_ALIGN]))
		else $error("receive counter moved while receive disabled");

	a_sat_hold: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && state_q.cnt[CI_CRC] == CNT_MAX[CI_CRC])
		|=> state_q.cnt[CI_CRC] == CNT_MAX[CI_CRC])
		else $error("counter wrapped past all ones");

	a_read_clears: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(bus_take && !i_wb.we && i_wb.adr[7:2] == CNT_OFF[CI_DEFER][7:2] && !i_tx.valid)
		|=> state_q.cnt[CI_DEFER] == CNT_RST &&
			state_q.rdat[CNT_W-1:0] == $past(state_q.cnt[CI_DEFER]) && state_q.ack)
		else $error("read did not return and clear the counter");

	a_write_locked: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(bus_take && i_wb.we && !state_q.ctrl[CTRL_STWR_BIT] && !i_tx.valid && !i_rx.valid)
		|=> $stable(state_q.cnt))
		else $error("counter written while writes are locked");

	a_closs_hdx: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && i_tx.valid && !state_q.ctrl[CTRL_HDX_BIT])
		|=> $stable(state_q.cnt[CI_CLOSS]))
		else $error("carrier loss counted in full duplex");

	a_big_frame_limit: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && i_rx.valid && i_rx.len > LEN_MAX && !state_q.ctrl[CTRL_BIG_BIT])
		|=> $stable(state_q.cnt[CI_GOODRX]))
		else $error("oversize frame counted as good");

	a_defer_no_coll: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && i_tx.valid && i_tx.ncoll != 5'd0)
		|=> $stable(state_q.cnt[CI_DEFER]))
		else $error("collided frame counted as deferred");

	a_ack_one_cycle: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		bus_take |=> state_q.ack ##1 !state_q.ack)
		else $error("bus answer not a single cycle after request");

	a_write_lands: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(bus_take && i_wb.we && state_q.ctrl[CTRL_STWR_BIT] && i_wb.sel == 4'hf &&
			i_wb.adr[7:2] == CNT_OFF[CI_STARVE][7:2])
		|=> state_q.cnt[CI_STARVE] == ($past(i_wb.dat[CNT_W-1:0]) & CNT_MAX[CI_STARVE]))
		else $error("enabled counter write did not land");

	a_multi_coll_count: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && i_tx.valid && !i_tx.underrun && i_tx.ncoll >= 5'h02 &&
			i_tx.ncoll <= COLL_MULTI_HI && state_q.cnt[CI_MCOL] != CNT_MAX[CI_MCOL])
		|=> state_q.cnt[CI_MCOL] == $past(state_q.cnt[CI_MCOL]) + 24'h000001)
		else $error("multiple collision frame not counted");

	a_excess_not_multi: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && i_tx.valid && i_tx.ncoll == COLL_EXCESS)
		|=> $stable(state_q.cnt[CI_MCOL]) && $stable(state_q.cnt[CI_SCOL]))
		else $error("abandoned frame counted as sent");

	a_defer_count: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && i_tx.valid && !i_tx.underrun && i_tx.deferred && i_tx.ncoll == 5'h00 &&
			state_q.cnt[CI_DEFER] != CNT_MAX[CI_DEFER])
		|=> state_q.cnt[CI_DEFER] == $past(state_q.cnt[CI_DEFER]) + 24'h000001)
		else $error("deferred frame not counted");

	a_late_count: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && i_tx.valid && !i_tx.underrun && i_tx.late_coll &&
			state_q.cnt[CI_LATE] != CNT_MAX[CI_LATE])
		|=> state_q.cnt[CI_LATE] == $past(state_q.cnt[CI_LATE]) + 24'h000001)
		else $error("late collision not counted");

	a_late_also_coll: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && i_tx.valid && !i_tx.underrun && i_tx.late_coll && i_tx.ncoll >= 5'h02 &&
			i_tx.ncoll <= COLL_MULTI_HI && state_q.cnt[CI_MCOL] != CNT_MAX[CI_MCOL])
		|=> state_q.cnt[CI_MCOL] == $past(state_q.cnt[CI_MCOL]) + 24'h000001)
		else $error("late collision missing from collision count");

	a_excess_count: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && i_tx.valid && !i_tx.underrun && i_tx.ncoll == COLL_EXCESS &&
			state_q.cnt[CI_EXCESS_COLLISION_TALLY] != CNT_MAX[CI_EXCESS_COLLISION_TALLY])
		|=> state_q.cnt[CI_EXCESS_COLLISION_TALLY] == $past(state_q.cnt[CI_EXCESS_COLLISION_TALLY]) + 24'h000001)
		else $error("abandoned frame not counted");

	a_starve_count: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && i_tx.valid && i_tx.underrun &&
			state_q.cnt[CI_STARVE] != CNT_MAX[CI_STARVE])
		|=> state_q.cnt[CI_STARVE] == $past(state_q.cnt[CI_STARVE]) + 24'h000001)
		else $error("starved frame not counted");

	a_closs_count: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && i_tx.valid && !i_tx.underrun && i_tx.carrier_err && i_tx.ncoll == 5'h00 &&
			state_q.ctrl[CTRL_HDX_BIT] && state_q.cnt[CI_CLOSS] != CNT_MAX[CI_CLOSS])
		|=> state_q.cnt[CI_CLOSS] == $past(state_q.cnt[CI_CLOSS]) + 24'h000001)
		else $error("carrier loss not counted");

	a_closs_collided: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && i_tx.valid && i_tx.ncoll != 5'h00)
		|=> $stable(state_q.cnt[CI_CLOSS]))
		else $error("carrier loss counted on a collided frame");

	a_carrier_alone: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && i_tx.valid && i_tx.carrier_err && i_tx.ncoll == 5'h00 && !i_tx.late_coll &&
			!i_tx.deferred)
		|=> $stable(state_q.cnt[CI_SCOL]) && $stable(state_q.cnt[CI_MCOL]) &&
			$stable(state_q.cnt[CI_DEFER]) && $stable(state_q.cnt[CI_LATE]) &&
			$stable(state_q.cnt[CI_EXCESS_COLLISION_TALLY]))
		else $error("carrier sense error moved another counter");

	a_tx_quiet_hold: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && !i_tx.valid)
		|=> $stable(state_q.cnt[CI_SCOL]) && $stable(state_q.cnt[CI_MCOL]) &&
			$stable(state_q.cnt[CI_DEFER]) && $stable(state_q.cnt[CI_LATE]) &&
			$stable(state_q.cnt[CI_EXCESS_COLLISION_TALLY]) && $stable(state_q.cnt[CI_STARVE]) &&
			$stable(state_q.cnt[CI_CLOSS]))
		else $error("transmit counter moved without a frame");

	a_good_rx_count: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && i_rx.valid && state_q.ctrl[CTRL_RXEN_BIT] && i_rx.len >= LEN_MIN &&
			i_rx.len <= LEN_MAX && !i_rx.crc_bad && !i_rx.sym_err && i_rx.addr_match &&
			i_rx.stored && state_q.cnt[CI_GOODRX] != CNT_MAX[CI_GOODRX])
		|=> state_q.cnt[CI_GOODRX] == $past(state_q.cnt[CI_GOODRX]) + 24'h000001)
		else $error("good frame not counted");

	a_good_rx_unmatched: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && i_rx.valid && !(i_rx.addr_match && i_rx.stored))
		|=> $stable(state_q.cnt[CI_GOODRX]))
		else $error("unmatched or unstored frame counted as good");

	a_good_rx_errors: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && i_rx.valid && (i_rx.crc_bad || i_rx.sym_err))
		|=> $stable(state_q.cnt[CI_GOODRX]))
		else $error("errored frame counted as good");

	a_big_frame_max: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && i_rx.valid && i_rx.len > LEN_MAX_BIG)
		|=> $stable(state_q.cnt[CI_GOODRX]))
		else $error("frame above large limit counted as good");

	a_crc_count: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && i_rx.valid && state_q.ctrl[CTRL_RXEN_BIT] && i_rx.len >= LEN_MIN &&
			i_rx.len <= LEN_MAX && !i_rx.odd_bits && (i_rx.crc_bad || i_rx.sym_err) &&
			state_q.cnt[CI_CRC] != CNT_MAX[CI_CRC])
		|=> state_q.cnt[CI_CRC] == $past(state_q.cnt[CI_CRC]) + 24'h000001)
		else $error("crc error not counted");

	a_crc_whole_only: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && i_rx.valid && i_rx.odd_bits)
		|=> $stable(state_q.cnt[CI_CRC]))
		else $error("frame with stray bits counted as crc error");

	a_align_count: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && i_rx.valid && state_q.ctrl[CTRL_RXEN_BIT] && i_rx.len >= LEN_MIN &&
			i_rx.len <= LEN_MAX && i_rx.odd_bits && (i_rx.crc_bad || i_rx.sym_err) &&
			state_q.cnt[CI_ALIGN] != CNT_MAX[CI_ALIGN])
		|=> state_q.cnt[CI_ALIGN] == $past(state_q.cnt[CI_ALIGN]) + 24'h000001)
		else $error("alignment error not counted");

	a_err_bad_len: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && i_rx.valid && (i_rx.len < LEN_MIN || i_rx.len > LEN_MAX_BIG ||
			(i_rx.len > LEN_MAX && !state_q.ctrl[CTRL_BIG_BIT])))
		|=> $stable(state_q.cnt[CI_CRC]) && $stable(state_q.cnt[CI_ALIGN]))
		else $error("error counted on a frame of bad length");

	a_rx_quiet_hold: assert property (
		@(posedge i_clk_sys) disable iff (i_rst)
		(quiet && !i_rx.valid)
		|=> $stable(state_q.cnt[CI_GOODRX]) && $stable(state_q.cnt[CI_CRC]) &&
			$stable(state_q.cnt[CI_ALIGN]))
		else $error("receive counter moved without a frame");

	// every counter gets the same bound and step checks
	for (genvar g = 0; g < NCNT; g++) begin : g_cnt_chk
		a_cnt_bounded: assert property (
			@(posedge i_clk_sys) disable iff (i_rst)
			state_q.cnt[g] <= CNT_MAX[g])
			else $error("counter above its width");

		a_cnt_one_step: assert property (
			@(posedge i_clk_sys) disable iff (i_rst)
			quiet |=> (state_q.cnt[g] == $past(state_q.cnt[g])) ||
				(state_q.cnt[g] == $past(state_q.cnt[g]) + 24'h000001))
			else $error("counter moved more than one step");
	end

endmodule

/* tb/msc_mac_model.sv */
// partner: mac engines that hand final frame status to the counters
`timescale 1ns/100ps

module msc_mac_model (
	// clock
	input  wire logic             i_clk_sys,
	// frame status toward the counters
	output msc_pkg::msc_tx_stat_t o_tx,
	output msc_pkg::msc_rx_stat_t o_rx
);
	import msc_pkg::*;

	initial begin
		o_tx = '0;
		o_rx = '0;
	end

	// between frames the fields show the inverse of the last frame, so stale status never
	// looks like a repeat of the previous frame
	task automatic send(input msc_tx_stat_t t, input msc_rx_stat_t r, input int n);
		msc_tx_stat_t ti;
		msc_rx_stat_t ri;
		ti = ~t;
		ti.valid = 1'b0;
		ri = ~r;
		ri.valid = 1'b0;
		@(posedge i_clk_sys);
		o_tx <= t;
		o_rx <= r;
		repeat (n) @(posedge i_clk_sys); // one final status per frame, back to back
		o_tx <= ti;
		o_rx <= ri;
	endtask
endmodule

/* tb/msc_stats_tb_top.sv */
// bench: register and frame status scenarios for the statistics counters
`timescale 1ns/100ps

module msc_stats_tb_top;
	import msc_pkg::*;

	logic         i_clk_sys;
	logic         i_rst;
	msc_wb_req_t  wb;
	msc_wb_rsp_t  rsp;
	msc_tx_stat_t tx;
	msc_rx_stat_t rx;
	int           n_errors;
	int           n_compared;
	int           cycles;
	logic [31:0]  v;
	localparam logic [31:0] C = 32'h0000_0204;
	localparam logic [4:0]  G = 5'b00011;

	msc_stats dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_wb(wb), .o_wb(rsp),
		.i_tx(tx), .i_rx(rx));
	msc_mac_model mac_u (.i_clk_sys(i_clk_sys), .o_tx(tx), .o_rx(rx));

	always #4 i_clk_sys = ~i_clk_sys;

	// a whole run needs about 1250 cycles
	always @(posedge i_clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			n_errors = n_errors + 1;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one classic cycle; read data lands in v
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		wb <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
		do @(posedge i_clk_sys); while (rsp.ack !== 1'b1);
		v = rsp.dat;
		wb <= '0;
	endtask

	function automatic msc_tx_stat_t ft(input logic [4:0] c, input logic [3:0] f);
		return {1'b1, c, f};
	endfunction

	function automatic msc_rx_stat_t fr(input logic [13:0] l, input logic [4:0] f);
		return {1'b1, l, f};
	endfunction

	// reads clear, so each case starts from zero; m marks the counters that must move
	task automatic run(input logic [31:0] c, input msc_tx_stat_t t, input msc_rx_stat_t r,
		input int n, input logic [9:0] m);
		acc(1'b1, OFF_CTRL, c);
		mac_u.send(t, r, n);
		for (int i = 0; i < NCNT; i++) begin
			acc(1'b0, CNT_OFF[i], '0);
			chk($sformatf("cnt%0d", i), v, 32'(m[i] ? n : 0));
		end
	endtask

	initial begin
		i_clk_sys = 1'b0;
		i_rst = 1'b1;
		wb = '0;
		n_errors = 0;
		n_compared = 0;
		cycles = 0;
		repeat (5) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		acc(1'b0, OFF_CTRL, '0);
		chk("ctrl", v, CTRL_RST);
		acc(1'b1, 8'h3c, '1);
		acc(1'b0, 8'h3c, '0);
		chk("unmapped", v, '0);
		acc(1'b1, OFF_CTRL, '1);
		acc(1'b0, OFF_CTRL, '0);
		chk("ctrl", v, CTRL_MASK);
		for (int i = 0; i < NCNT; i++) begin
			acc(1'b0, CNT_OFF[i], '0);
			chk("reset", v, {8'h00, CNT_RST});
			acc(1'b1, CNT_OFF[i], '1);
			acc(1'b0, CNT_OFF[i], '0);
			chk("width", v, {8'h00, CNT_MAX[i]});
			acc(1'b0, CNT_OFF[i], '0);
			chk("clear", v, '0);
		end
		acc(1'b1, CNT_OFF[CI_GOODRX], '1);
		mac_u.send('0, fr(14'd64, G), 1);
		acc(1'b0, CNT_OFF[CI_GOODRX], '0);
		chk("sticky", v, 32'h00ff_ffff);
		acc(1'b1, OFF_CTRL, C);
		acc(1'b1, CNT_OFF[CI_CRC], 32'h55);
		acc(1'b0, CNT_OFF[CI_CRC], '0);
		chk("locked", v, '0);
		run(C, ft(5'd1, 4'h0), '0, 1, 10'h001);
		run(C, ft(5'd2, 4'h0), '0, 1, 10'h002);
		run(C, ft(5'd15, 4'h0), '0, 1, 10'h002);
		run(C, ft(5'd16, 4'h0), '0, 1, 10'h080);
		run(C, ft(5'd3, 4'h8), '0, 1, 10'h042);
		run(C, ft(5'd1, 4'h8), '0, 1, 10'h041);
		run(C, ft(5'd0, 4'h2), '0, 1, 10'h020);
		run(C, ft(5'd1, 4'h2), '0, 1, 10'h001);
		run(C, ft(5'd0, 4'h6), '0, 1, 10'h100);
		run(C, ft(5'd2, 4'hd), '0, 1, 10'h100);
		run(C, ft(5'd0, 4'h1), '0, 1, 10'h200);
		run(C, ft(5'd0, 4'h3), '0, 1, 10'h220);
		run(C, ft(5'd1, 4'h1), '0, 1, 10'h001);
		run(32'h4, ft(5'd0, 4'h1), '0, 1, 10'h000);
		run(C, '0, fr(14'd64, G), 1, 10'h004);
		run(C, '0, fr(14'd1518, G), 1, 10'h004);
		run(C, '0, fr(14'd1519, G), 1, 10'h000);
		run(C, '0, fr(14'd63, G), 1, 10'h000);
		run(32'h304, '0, fr(14'd1536, G), 1, 10'h004);
		run(32'h304, '0, fr(14'd1537, G), 1, 10'h000);
		run(C, '0, fr(14'd64, 5'b00001), 1, 10'h000);
		run(C, '0, fr(14'd64, 5'b00010), 1, 10'h000);
		run(C, '0, fr(14'd100, 5'b01011), 1, 10'h008);
		run(C, '0, fr(14'd100, 5'b00111), 1, 10'h008);
		run(C, '0, fr(14'd100, 5'b11011), 1, 10'h010);
		run(C, '0, fr(14'd100, 5'b10111), 1, 10'h010);
		run(C, '0, fr(14'd1519, 5'b01011), 1, 10'h000);
		run(32'h200, '0, fr(14'd64, G), 1, 10'h000);
		run(32'h200, '0, fr(14'd64, 5'b01011), 1, 10'h000);
		run(C, ft(5'd1, 4'h0), fr(14'd64, G), 3, 10'h005);
		finish_test();
	end
endmodule
